// ==== timer_sync_pkg.sv ====
// constants shared by the timer synchronisation block
package timer_sync_pkg;
	localparam int unsigned U1_CH_DEF = 8;
	localparam int unsigned U2_CH_DEF = 4;
	localparam int unsigned U1_CNT_W_DEF = 16;
	localparam int unsigned U2_CNT_W_DEF = 32;
	localparam int unsigned EV_N = 2;
	// hardware source vector: [3:0] triggers a..d, [5:4] events, [6] pin a, [7] pin b
	localparam int unsigned SRC_W = 8;
	localparam int unsigned SRC_EV_LSB = 4;
	localparam int unsigned SRC_PIN_A = 6;
	localparam int unsigned SRC_PIN_B = 7;
	// general group of the first unit is channels 0..5, special pair 6..7
	localparam int unsigned U1_GEN_N = 6;
	localparam int unsigned U1_SPEC_LSB = 6;
	// unit 1 map
	localparam logic [11:0] OFF_U1_START_A = 12'h000;
	localparam logic [11:0] OFF_U1_START_B = 12'h004;
	localparam logic [11:0] OFF_U1_COMMON_START = 12'h008;
	localparam logic [11:0] OFF_U1_SYNC_A = 12'h00c;
	localparam logic [11:0] OFF_U1_SYNC_B = 12'h010;
	localparam logic [11:0] OFF_U1_CTRL = 12'h014;
	localparam logic [11:0] OFF_U1_SPEC_CLR = 12'h018;
	localparam logic [11:0] OFF_U1_CNT_BASE = 12'h020;
	// unit 2 per-channel blocks, each a full copy of the shared registers
	localparam logic [11:0] OFF_U2_BASE = 12'h040;
	localparam int unsigned U2_STRIDE_LOG2 = 5;
	localparam logic [4:0] OFF_U2_START = 5'h00;
	localparam logic [4:0] OFF_U2_STOP = 5'h04;
	localparam logic [4:0] OFF_U2_CLEAR = 5'h08;
	localparam logic [4:0] OFF_U2_HW_START = 5'h0c;
	localparam logic [4:0] OFF_U2_HW_STOP = 5'h10;
	localparam logic [4:0] OFF_U2_HW_CLEAR = 5'h14;
	localparam logic [4:0] OFF_U2_CNT = 5'h18;
	// counter clear select field, two bits per channel
	localparam int unsigned CCS_W = 2;
	typedef enum logic [1:0] {
		CCS_NONE = 2'h0,
		CCS_OWN_MATCH = 2'h1,
		CCS_SYNC = 2'h2
	} ccs_t;
	// special clear source register fields
	localparam int unsigned SPC_SEL_LSB = 0;
	localparam int unsigned SPC_SEL_W = 4;
	localparam int unsigned SPC_EN6_BIT = 4;
	localparam int unsigned SPC_EN7_BIT = 5;
	localparam logic [3:0] SPC_SEL_MAX = 4'hb;
	localparam logic [7:0] RESET_ZERO = 8'h00;
endpackage

// ==== unit2_channel.sv ====
// one channel of the second unit: source selects, run state and counter
`timescale 1ns/1ps
module unit2_channel #(
	parameter int unsigned CNT_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sw_start,
	input wire logic sw_stop,
	input wire logic sw_clear,
	input wire logic wr_hw_start,
	input wire logic wr_hw_stop,
	input wire logic wr_hw_clear,
	input wire logic [timer_sync_pkg::SRC_W-1:0] wdata,
	input wire logic [timer_sync_pkg::SRC_W-1:0] src_pulse,
	output logic [timer_sync_pkg::SRC_W-1:0] unit2_hw_start_source_reg,
	output logic [timer_sync_pkg::SRC_W-1:0] unit2_hw_stop_source_reg,
	output logic [timer_sync_pkg::SRC_W-1:0] unit2_hw_clear_source_reg,
	output logic run_reg,
	output logic [CNT_W-1:0] unit2_channel_counter
);
	import timer_sync_pkg::*;
	logic hw_start;
	logic hw_stop;
	logic hw_clear;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit2_hw_start_source_reg <= '0;
			unit2_hw_stop_source_reg <= '0;
			unit2_hw_clear_source_reg <= '0;
		end else begin
			if (wr_hw_start) unit2_hw_start_source_reg <= wdata;
			if (wr_hw_stop) unit2_hw_stop_source_reg <= wdata;
			if (wr_hw_clear) unit2_hw_clear_source_reg <= wdata;
		end
	end

	assign hw_start = |(unit2_hw_start_source_reg & src_pulse);
	assign hw_stop = |(unit2_hw_stop_source_reg & src_pulse);
	assign hw_clear = |(unit2_hw_clear_source_reg & src_pulse);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
		end else if (sw_stop || hw_stop) begin
			run_reg <= 1'b0;
		end else if (sw_start || hw_start) begin
			run_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit2_channel_counter <= '0;
		end else if (sw_clear || hw_clear) begin
			unit2_channel_counter <= '0;
		end else if (run_reg) begin
			unit2_channel_counter <= unit2_channel_counter + 1'b1;
		end
	end
endmodule

// ==== timer_sync.sv ====
// synchronised start, stop and clear for two multi-channel timer units
`timescale 1ns/1ps
// Summary of operation
// - In unit 1, a one written to a channel bit of a start register starts that counter, all such bits together.
// - The common start register of unit 1 starts general and special channels in one write.
// - In unit 1, a zero written to a channel bit of start register A or B stops that counter, all together; the common start register ignores zeros.
// - In unit 2, a one written to the shared start register through any copy starts those channels.
// - In unit 2, a one written to the shared stop register through any copy stops those channels; zero does nothing.
// - In unit 2, a one written to the shared clear register through any copy clears those counters at once.
// - In unit 1, the clear select field and sync registers pick a compare match that clears all participants together.
// - The special channels clear on the compare interrupt A to D of channel 0 to 2 chosen in their clear source register.
// - An event link start pulse sets the target channels' run bits in unit 1.
// - An event link restart pulse clears the target channels' counters in unit 1.
// - Unit 1 channels hit by the same event act in the same cycle.
// - Each unit 2 channel starts on any source picked in its hardware start select register.
// - Each unit 2 channel stops on any source picked in its hardware stop select register.
// - Each unit 2 channel clears on any source picked in its hardware clear select register.
module timer_sync #(
	parameter int unsigned U1_CH = timer_sync_pkg::U1_CH_DEF,
	parameter int unsigned U2_CH = timer_sync_pkg::U2_CH_DEF,
	parameter int unsigned U1_CNT_W = timer_sync_pkg::U1_CNT_W_DEF,
	parameter int unsigned U2_CNT_W = timer_sync_pkg::U2_CNT_W_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [U1_CH*4-1:0] compare_match_interrupt,
	input wire logic [U1_CH-1:0] event_start_pulse,
	input wire logic [U1_CH-1:0] event_restart_pulse,
	input wire logic [timer_sync_pkg::EV_N-1:0] unit2_event_pulse,
	input wire logic external_trigger_a,
	input wire logic external_trigger_b,
	input wire logic external_trigger_c,
	input wire logic external_trigger_d,
	input wire logic [U2_CH-1:0] channel_pin_a,
	input wire logic [U2_CH-1:0] channel_pin_b,
	output logic [U1_CH-1:0] unit1_channel_run_bit,
	output logic [U1_CH*U1_CNT_W-1:0] unit1_channel_counter,
	output logic [U2_CH-1:0] unit2_run,
	output logic [U2_CH*U2_CNT_W-1:0] unit2_channel_counter
);
	import timer_sync_pkg::*;

	localparam int unsigned RAW_W = 4 + 2 * U2_CH;
	localparam int unsigned U2_SPAN = U2_CH << U2_STRIDE_LOG2;

	logic wr_en;
	logic [U1_CH-1:0] unit1_sync_mode_reg;
	logic [U1_CH*CCS_W-1:0] unit1_channel_control_reg;
	logic [7:0] special_channel_clear_source_reg;
	logic [RAW_W-1:0] raw_in;
	logic [RAW_W-1:0] sync1_reg;
	logic [RAW_W-1:0] sync2_reg;
	logic [RAW_W-1:0] sync3_reg;
	logic [RAW_W-1:0] rise;
	logic [U1_CH-1:0] u1_set;
	logic [U1_CH-1:0] u1_stop;
	logic [U1_CH-1:0] u1_clear;
	logic [U1_CH-1:0] own_match;
	logic sync_fire;
	logic spec_fire;
	logic in_u2;
	logic [11:0] u2_rel;
	logic [11:0] u2_ch_idx;
	logic [4:0] u2_off;
	logic u2_sw_wr_start;
	logic u2_sw_wr_stop;
	logic u2_sw_wr_clear;
	logic [U2_CH*SRC_W-1:0] u2_hw_start_regs;
	logic [U2_CH*SRC_W-1:0] u2_hw_stop_regs;
	logic [U2_CH*SRC_W-1:0] u2_hw_clear_regs;

	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;

	// unit 2 decode: any channel's block reaches the shared registers
	assign in_u2 = (paddr >= OFF_U2_BASE) && (paddr < OFF_U2_BASE + U2_SPAN[11:0]);
	assign u2_rel = paddr - OFF_U2_BASE;
	assign u2_ch_idx = u2_rel >> U2_STRIDE_LOG2;
	assign u2_off = u2_rel[4:0];
	assign u2_sw_wr_start = wr_en && in_u2 && (u2_off == OFF_U2_START);
	assign u2_sw_wr_stop = wr_en && in_u2 && (u2_off == OFF_U2_STOP);
	assign u2_sw_wr_clear = wr_en && in_u2 && (u2_off == OFF_U2_CLEAR);

	// two-flop synchronisers, third stage only feeds the edge detector
	assign raw_in = {channel_pin_b, channel_pin_a, external_trigger_d, external_trigger_c,
		external_trigger_b, external_trigger_a};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign rise = sync2_reg & ~sync3_reg;

	// unit 1 configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit1_sync_mode_reg <= '0;
			unit1_channel_control_reg <= '0;
			special_channel_clear_source_reg <= RESET_ZERO;
		end else if (wr_en) begin
			if (paddr == OFF_U1_SYNC_A) unit1_sync_mode_reg[U1_GEN_N-1:0] <= pwdata[U1_GEN_N-1:0];
			if (paddr == OFF_U1_SYNC_B) unit1_sync_mode_reg[U1_CH-1:U1_SPEC_LSB] <= pwdata[U1_CH-U1_SPEC_LSB-1:0];
			if (paddr == OFF_U1_CTRL) unit1_channel_control_reg <= pwdata[U1_CH*CCS_W-1:0];
			if (paddr == OFF_U1_SPEC_CLR) special_channel_clear_source_reg <= pwdata[7:0];
		end
	end

	// special pair clears on one chosen compare interrupt of channels 0..2
	always_comb begin
		logic [SPC_SEL_W-1:0] sel;
		sel = special_channel_clear_source_reg[SPC_SEL_LSB +: SPC_SEL_W];
		spec_fire = (sel <= SPC_SEL_MAX) && compare_match_interrupt[sel];
	end

	// per-channel start, stop and clear requests
	always_comb begin
		u1_set = '0;
		u1_stop = '0;
		u1_clear = '0;
		own_match = '0;
		sync_fire = 1'b0;
		for (int i = 0; i < U1_CH; i++) begin
			own_match[i] = compare_match_interrupt[i*4] &&
				(unit1_channel_control_reg[i*CCS_W +: CCS_W] == CCS_OWN_MATCH);
			if (own_match[i] && unit1_sync_mode_reg[i]) sync_fire = 1'b1;
		end
		// start b bits sit at the bottom of the word; own loop keeps every index in range
		for (int unsigned j = 0; j < U1_CH - U1_SPEC_LSB; j++) begin
			if (wr_en && paddr == OFF_U1_START_B) begin
				u1_set[U1_SPEC_LSB+j] = pwdata[j];
				u1_stop[U1_SPEC_LSB+j] = !pwdata[j];
			end
		end
		for (int i = 0; i < U1_CH; i++) begin
			if (wr_en && paddr == OFF_U1_START_A && i < U1_GEN_N) begin
				u1_set[i] = pwdata[i];
				u1_stop[i] = !pwdata[i];
			end
			if (wr_en && paddr == OFF_U1_COMMON_START && pwdata[i]) u1_set[i] = 1'b1;
			if (event_start_pulse[i]) u1_set[i] = 1'b1;
			u1_clear[i] = own_match[i] || event_restart_pulse[i] ||
				(sync_fire && unit1_sync_mode_reg[i] &&
				unit1_channel_control_reg[i*CCS_W +: CCS_W] == CCS_SYNC);
		end
		if (spec_fire && special_channel_clear_source_reg[SPC_EN6_BIT]) u1_clear[U1_SPEC_LSB] = 1'b1;
		if (spec_fire && special_channel_clear_source_reg[SPC_EN7_BIT]) u1_clear[U1_SPEC_LSB+1] = 1'b1;
	end

	// unit 1 run bits and counters, one loop so every channel acts together
	for (genvar g = 0; g < U1_CH; g++) begin : g_u1
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				unit1_channel_run_bit[g] <= 1'b0;
			end else if (u1_stop[g]) begin
				unit1_channel_run_bit[g] <= 1'b0;
			end else if (u1_set[g]) begin
				unit1_channel_run_bit[g] <= 1'b1;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				unit1_channel_counter[g*U1_CNT_W +: U1_CNT_W] <= '0;
			end else if (u1_clear[g]) begin
				unit1_channel_counter[g*U1_CNT_W +: U1_CNT_W] <= '0;
			end else if (unit1_channel_run_bit[g]) begin
				unit1_channel_counter[g*U1_CNT_W +: U1_CNT_W] <=
					unit1_channel_counter[g*U1_CNT_W +: U1_CNT_W] + 1'b1;
			end
		end
	end

	// unit 2 channels; shared strobes reach every channel in the same cycle
	for (genvar g = 0; g < U2_CH; g++) begin : g_u2
		logic [SRC_W-1:0] src;
		logic sel_ch;
		assign sel_ch = wr_en && in_u2 && (u2_ch_idx == g);
		assign src = {rise[4+U2_CH+g], rise[4+g], unit2_event_pulse, rise[3:0]};

		unit2_channel #(
			.CNT_W(U2_CNT_W)
		) u_ch (
			.pclk(pclk),
			.presetn(presetn),
			.sw_start(u2_sw_wr_start && pwdata[g]),
			.sw_stop(u2_sw_wr_stop && pwdata[g]),
			.sw_clear(u2_sw_wr_clear && pwdata[g]),
			.wr_hw_start(sel_ch && u2_off == OFF_U2_HW_START),
			.wr_hw_stop(sel_ch && u2_off == OFF_U2_HW_STOP),
			.wr_hw_clear(sel_ch && u2_off == OFF_U2_HW_CLEAR),
			.wdata(pwdata[SRC_W-1:0]),
			.src_pulse(src),
			.unit2_hw_start_source_reg(u2_hw_start_regs[g*SRC_W +: SRC_W]),
			.unit2_hw_stop_source_reg(u2_hw_stop_regs[g*SRC_W +: SRC_W]),
			.unit2_hw_clear_source_reg(u2_hw_clear_regs[g*SRC_W +: SRC_W]),
			.run_reg(unit2_run[g]),
			.unit2_channel_counter(unit2_channel_counter[g*U2_CNT_W +: U2_CNT_W])
		);
	end

	// read mux and error on unmapped addresses
	always_comb begin
		int unsigned ci;
		ci = 0;
		prdata = '0;
		pslverr = 1'b0;
		if (in_u2) begin
			ci = 32'(u2_ch_idx);
			unique case (u2_off)
				OFF_U2_START: prdata[U2_CH-1:0] = unit2_run;
				OFF_U2_STOP: prdata = '0;
				OFF_U2_CLEAR: prdata = '0;
				OFF_U2_HW_START: prdata[SRC_W-1:0] = u2_hw_start_regs[ci*SRC_W +: SRC_W];
				OFF_U2_HW_STOP: prdata[SRC_W-1:0] = u2_hw_stop_regs[ci*SRC_W +: SRC_W];
				OFF_U2_HW_CLEAR: prdata[SRC_W-1:0] = u2_hw_clear_regs[ci*SRC_W +: SRC_W];
				OFF_U2_CNT: prdata[U2_CNT_W-1:0] = unit2_channel_counter[ci*U2_CNT_W +: U2_CNT_W];
				default: pslverr = psel && penable;
			endcase
		end else if (paddr >= OFF_U1_CNT_BASE && paddr < OFF_U1_CNT_BASE + 12'(U1_CH*4) && paddr[1:0] == 2'h0) begin
			ci = 32'((paddr - OFF_U1_CNT_BASE) >> 2);
			prdata[U1_CNT_W-1:0] = unit1_channel_counter[ci*U1_CNT_W +: U1_CNT_W];
		end else begin
			unique case (paddr)
				OFF_U1_START_A: prdata[U1_GEN_N-1:0] = unit1_channel_run_bit[U1_GEN_N-1:0];
				OFF_U1_START_B: prdata[U1_CH-U1_SPEC_LSB-1:0] = unit1_channel_run_bit[U1_CH-1:U1_SPEC_LSB];
				OFF_U1_COMMON_START: prdata[U1_CH-1:0] = unit1_channel_run_bit;
				OFF_U1_SYNC_A: prdata[U1_GEN_N-1:0] = unit1_sync_mode_reg[U1_GEN_N-1:0];
				OFF_U1_SYNC_B: prdata[U1_CH-U1_SPEC_LSB-1:0] = unit1_sync_mode_reg[U1_CH-1:U1_SPEC_LSB];
				OFF_U1_CTRL: prdata[U1_CH*CCS_W-1:0] = unit1_channel_control_reg;
				OFF_U1_SPEC_CLR: prdata[7:0] = special_channel_clear_source_reg;
				default: pslverr = psel && penable;
			endcase
		end
	end
endmodule

// ==== timer_sync_monitor.sv ====
// assertion checker for the timer synchronisation block
`timescale 1ns/1ps
module timer_sync_monitor #(
	parameter int unsigned U1_CH = 8,
	parameter int unsigned U2_CH = 4,
	parameter int unsigned U1_CNT_W = 16,
	parameter int unsigned U2_CNT_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [U1_CH-1:0] event_start_pulse,
	input wire logic [U1_CH-1:0] event_restart_pulse,
	input wire logic [U1_CH-1:0] unit1_channel_run_bit,
	input wire logic [U1_CH*U1_CNT_W-1:0] unit1_channel_counter,
	input wire logic [U2_CH-1:0] unit2_run,
	input wire logic [U2_CH*U2_CNT_W-1:0] unit2_channel_counter
);
	logic wr;
	logic u2_wr;
	logic [U1_CNT_W-1:0] c3;
	assign wr = psel && penable && pwrite;
	assign u2_wr = wr && paddr >= 12'h040 && paddr < 12'h0c0;
	assign c3 = unit1_channel_counter[3*U1_CNT_W +: U1_CNT_W];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_U1_START_A: assert property (
		wr && paddr == 12'h000 |=> unit1_channel_run_bit[5:0] == $past(pwdata[5:0]))
		else $error("start register a mismatch");
	AST_U1_START_B: assert property (
		wr && paddr == 12'h004 |=> unit1_channel_run_bit[7:6] == $past(pwdata[1:0]))
		else $error("start register b mismatch");
	AST_U1_COMMON: assert property (
		wr && paddr == 12'h008 |=> (unit1_channel_run_bit & $past(pwdata[7:0])) == $past(pwdata[7:0]))
		else $error("common start missed a channel");
	AST_EV_START: assert property (
		event_start_pulse[0] && !(wr && paddr == 12'h000 && !pwdata[0]) |=> unit1_channel_run_bit[0])
		else $error("event start ignored");
	AST_EV_RESTART: assert property (
		event_restart_pulse[0] |=> unit1_channel_counter[U1_CNT_W-1:0] == '0)
		else $error("event restart did not clear");
	AST_U1_HOLD: assert property (
		!$past(unit1_channel_run_bit[3]) |-> c3 == $past(c3) || c3 == '0)
		else $error("stopped counter moved");
	AST_U2_STOP: assert property (
		u2_wr && paddr[4:0] == 5'h04 |=> (unit2_run & $past(pwdata[3:0])) == 4'h0)
		else $error("shared stop ignored");
	AST_U2_CLEAR: assert property (
		u2_wr && paddr[4:0] == 5'h08 && pwdata[1] |=> unit2_channel_counter[U2_CNT_W +: U2_CNT_W] == '0)
		else $error("shared clear ignored");
	AST_UNMAPPED: assert property (
		psel && penable && paddr == 12'h05c |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule
bind timer_sync timer_sync_monitor #(.U1_CH(U1_CH), .U2_CH(U2_CH), .U1_CNT_W(U1_CNT_W), .U2_CNT_W(U2_CNT_W)) mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .event_start_pulse(event_start_pulse),
	.event_restart_pulse(event_restart_pulse), .unit1_channel_run_bit(unit1_channel_run_bit),
	.unit1_channel_counter(unit1_channel_counter), .unit2_run(unit2_run),
	.unit2_channel_counter(unit2_channel_counter)
);

// ==== timer_sync_partner.sv ====
// model of the event link controller, trigger pins and sibling compare sources
`timescale 1ns/1ps
module timer_sync_partner (
	input wire logic pclk,
	output logic [31:0] compare_match_interrupt,
	output logic [7:0] event_start_pulse,
	output logic [7:0] event_restart_pulse,
	output logic [1:0] unit2_event_pulse,
	output logic [3:0] trig,
	output logic [3:0] channel_pin_a,
	output logic [3:0] channel_pin_b
);
	initial begin
		compare_match_interrupt = 32'h0;
		event_start_pulse = 8'h0;
		event_restart_pulse = 8'h0;
		unit2_event_pulse = 2'h0;
		trig = 4'h0;
		channel_pin_a = 4'h0;
		channel_pin_b = 4'h0;
	end
	// single-cycle strobes; the timer acts at the edge that ends them
	task automatic pulse(input logic [31:0] cm, input logic [7:0] st, input logic [7:0] rs, input logic [1:0] ue);
		@(posedge pclk);
		compare_match_interrupt <= cm;
		event_start_pulse <= st;
		event_restart_pulse <= rs;
		unit2_event_pulse <= ue;
		@(posedge pclk);
		compare_match_interrupt <= 32'h0;
		event_start_pulse <= 8'h0;
		event_restart_pulse <= 8'h0;
		unit2_event_pulse <= 2'h0;
		#1;
	endtask
	// levels; only a rising edge means anything to the timer
	task automatic levels(input logic [3:0] t, input logic [3:0] pa, input logic [3:0] pb);
		@(posedge pclk);
		trig <= t;
		channel_pin_a <= pa;
		channel_pin_b <= pb;
	endtask
endmodule

// ==== timer_sync_tb.sv ====
// self-checking bench for the timer synchronisation block
`timescale 1ns/1ps
module timer_sync_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, cm;
	logic [7:0] st, rs, run, v;
	logic [1:0] ue;
	logic [3:0] trig, pa, pb, u2run;
	logic [127:0] cnt1, cnt2;
	int error_cnt = 0, n_compared = 0;
	always #2.5 pclk = ~pclk;
	timer_sync_partner partner (.pclk(pclk), .compare_match_interrupt(cm), .event_start_pulse(st),
		.event_restart_pulse(rs), .unit2_event_pulse(ue), .trig(trig), .channel_pin_a(pa), .channel_pin_b(pb));
	timer_sync uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compare_match_interrupt(cm), .event_start_pulse(st), .event_restart_pulse(rs), .unit2_event_pulse(ue),
		.external_trigger_a(trig[0]), .external_trigger_b(trig[1]), .external_trigger_c(trig[2]),
		.external_trigger_d(trig[3]), .channel_pin_a(pa), .channel_pin_b(pb), .unit1_channel_run_bit(run),
		.unit1_channel_counter(cnt1), .unit2_run(u2run), .unit2_channel_counter(cnt2));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h014, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, 12'h05c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, 12'h000, 32'h5);
		repeat (4) @(posedge pclk);
		#1;
		chk("cnt0", 32'h4, cnt1[15:0]);
		chk("cnt2", 32'h4, cnt1[47:32]);
		apb(1'b1, 12'h000, 32'h1);
		chk("run", 32'h1, run);
		apb(1'b1, 12'h008, 32'hc2);
		chk("run", 32'hc3, run);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h004, 32'h0);
		partner.pulse(32'h0, 8'h19, 8'h0, 2'h0);
		chk("run", 32'h19, run);
		repeat (3) @(posedge pclk);
		#1;
		chk("cnt3", 32'h3, cnt1[63:48]);
		chk("cnt4", 32'h3, cnt1[79:64]);
		fork
			apb(1'b1, 12'h000, 32'h0);
			begin
				@(posedge pclk);
				partner.pulse(32'h0, 8'h02, 8'h0, 2'h0);
			end
		join
		chk("run", 32'h0, run);
		apb(1'b1, 12'h000, 32'h1);
		partner.pulse(32'h0, 8'h0, 8'h01, 2'h0);
		chk("cnt0", 32'h0, cnt1[15:0]);
		apb(1'b1, 12'h00c, 32'h30);
		apb(1'b1, 12'h014, 32'h900);
		apb(1'b0, 12'h014, 32'h0);
		chk("ctrl", 32'h900, rd);
		apb(1'b1, 12'h000, 32'h30);
		partner.pulse(32'h10000, 8'h0, 8'h0, 2'h0);
		chk("cnt4", 32'h0, cnt1[79:64]);
		chk("cnt5", 32'h0, cnt1[95:80]);
		apb(1'b1, 12'h004, 32'h3);
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, 12'h018, 32'h30 | 32'(i));
			partner.pulse(32'h1 << i, 8'h0, 8'h0, 2'h0);
			chk("cnt6", 32'h0, cnt1[111:96]);
			chk("cnt7", 32'h0, cnt1[127:112]);
		end
		// channel 2 ran from the start write until the stop write: 4 counted edges plus 3 of the stop access
		apb(1'b0, 12'h028, 32'h0);
		chk("cnt2_rd", 32'h7, rd);
		apb(1'b1, 12'h010, 32'h3);
		apb(1'b0, 12'h010, 32'h0);
		chk("sync_b", 32'h3, rd);
		apb(1'b1, 12'h080, 32'h5);
		chk("u2run", 32'h5, u2run);
		apb(1'b1, 12'h0a4, 32'h4);
		chk("u2run", 32'h1, u2run);
		apb(1'b1, 12'h044, 32'h0);
		chk("u2run", 32'h1, u2run);
		apb(1'b1, 12'h068, 32'h3);
		chk("u2cnt0", 32'h0, cnt2[31:0]);
		for (int s = 0; s < 8; s++) begin
			v = 8'h1 << s;
			apb(1'b1, 12'h04c, {24'h0, v});
			apb(1'b1, 12'h070, {24'h0, v});
			apb(1'b1, 12'h094, {24'h0, v});
			apb(1'b0, 12'h04c, 32'h0);
			chk("hw_src", {24'h0, v}, rd);
			apb(1'b1, 12'h040, 32'h6);
			apb(1'b1, 12'h044, 32'h1);
			if (s == 4 || s == 5) begin
				partner.pulse(32'h0, 8'h0, 8'h0, v[5:4]);
			end else begin
				partner.levels(v[3:0], {4{v[6]}}, {4{v[7]}});
				repeat (3) @(posedge pclk);
				#1;
			end
			chk("hw_start", 32'h1, {31'h0, u2run[0]});
			chk("hw_stop", 32'h0, {31'h0, u2run[1]});
			chk("hw_clear", 32'h0, cnt2[95:64]);
			partner.levels(4'h0, 4'h0, 4'h0);
			repeat (3) @(posedge pclk);
		end
		print_verdict;
	end
endmodule
